// ### hw/fcsd_host.v
`timescale 1ns/1ps
`include "fcsd_regs.vh"

module fcsd_host (
    input  wire        clk,
    input  wire        nrst,
    input  wire        cmd_valid,
    input  wire [3:0]  cmd_code,
    input  wire [21:0] cmd_addr,
    input  wire [15:0] cmd_data,
    input  wire        byte_mode,
    input  wire        op_done,
    input  wire        op_abort,
    input  wire        timeout_flag_bit,
    output reg         cmd_ready_ff,
    output reg         cmd_err_ff,
    output reg  [15:0] rd_data_ff,
    output reg         rd_valid_ff,
    output reg  [3:0]  mode_ff,
    output reg         esusp_ff,
    output reg         flash_ce_n_ff,
    output reg         flash_we_n_ff,
    output reg         flash_oe_n_ff,
    output reg         flash_byte_n_ff,
    output reg  [21:0] flash_addr_ff,
    output reg  [15:0] flash_dq_out_ff,
    output reg         flash_dq_oe_ff,
    input  wire [15:0] flash_dq_in
);

    localparam [3:0] M_READ  = 4'h0;
    localparam [3:0] M_ASEL  = 4'h1;
    localparam [3:0] M_QUERY = 4'h2;
    localparam [3:0] M_BUSY  = 4'h3;
    localparam [3:0] M_SERS  = 4'h4;
    localparam [3:0] M_ESUSP = 4'h5;
    localparam [3:0] M_ABORT = 4'h6;
    localparam [3:0] M_BUFLD = 4'h7;
    localparam [3:0] M_TOUT  = 4'h8;

    localparam [2:0] S_IDLE  = 3'h0;
    localparam [2:0] S_LOAD  = 3'h1;
    localparam [2:0] S_SETUP = 3'h2;
    localparam [2:0] S_PULSE = 3'h3;
    localparam [2:0] S_HOLD  = 3'h4;

    localparam [31:0] C_SU  = `FCSD_C_SU;
    localparam [31:0] C_WP  = `FCSD_C_WP;
    localparam [31:0] C_WPH = `FCSD_C_WPH;
    localparam [31:0] C_RD  = `FCSD_C_RD;

    reg [2:0]  st_ff;
    reg [7:0]  cnt_ff;
    reg [2:0]  step_ff;
    reg [3:0]  cmd_ff;
    reg [21:0] addr_ff;
    reg [15:0] data_ff;
    reg        byte_ff;
    reg [9:0]  sect_ff;
    reg [17:0] page_ff;
    reg        page_set_ff;
    reg [5:0]  left_ff;
    reg [15:0] dq_meta_ff;
    reg [15:0] dq_sync_ff;

    reg        legal;
    reg [2:0]  start_step;
    reg [21:0] st_addr;
    reg [15:0] st_data;
    reg        st_rd;
    reg        st_last;
    wire [21:0] u1   = byte_ff ? `FCSD_A_U1_BYTE : `FCSD_A_U1_WORD;
    wire [21:0] u2   = byte_ff ? `FCSD_A_U2_BYTE : `FCSD_A_U2_WORD;
    wire [21:0] uq   = byte_ff ? `FCSD_A_Q_BYTE : `FCSD_A_Q_WORD;
    wire [17:0] cpage = byte_mode ? {1'b0, cmd_addr[21:5]} : cmd_addr[21:4];
    wire [15:0] bmax  = byte_mode ? `FCSD_BUF_MAX_B : `FCSD_BUF_MAX_W;
    wire [9:0]  csect = cmd_addr[`FCSD_SECT_HI:`FCSD_SECT_LO];
    wire        cnt_su  = (cnt_ff == C_SU[7:0]);
    wire        cnt_pw  = (cnt_ff == (st_rd ? C_RD[7:0] : C_WP[7:0]));
    wire        cnt_wph = (cnt_ff == C_WPH[7:0]);

    // acceptance check per mode; refused commands never reach the pins
    always @* begin
        legal = 1'b0;
        start_step = 3'h0;
        case (mode_ff)
            M_READ: begin
                legal = (cmd_code != `FCSD_CMD_SUSPEND) && (cmd_code != `FCSD_CMD_RESUME) &&
                        (cmd_code != `FCSD_CMD_BUF_LOAD) && (cmd_code != `FCSD_CMD_BUF_CONF);
                if (cmd_code == `FCSD_CMD_BUF_START) begin
                    legal = (cmd_data <= bmax);
                end
            end
            M_ASEL, M_QUERY: begin
                legal = (cmd_code == `FCSD_CMD_READ) || (cmd_code == `FCSD_CMD_RESET) ||
                        (cmd_code == `FCSD_CMD_ASEL) || (cmd_code == `FCSD_CMD_QUERY);
                if (cmd_code == `FCSD_CMD_ASEL) begin
                    start_step = 3'h3;
                end
            end
            M_BUSY: legal = (cmd_code == `FCSD_CMD_READ);
            M_SERS: begin
                legal = (cmd_code == `FCSD_CMD_READ) || (cmd_code == `FCSD_CMD_SUSPEND);
            end
            M_ESUSP: begin
                legal = (cmd_code == `FCSD_CMD_READ) || (cmd_code == `FCSD_CMD_PROGRAM) ||
                        (cmd_code == `FCSD_CMD_ASEL) || (cmd_code == `FCSD_CMD_RESUME) ||
                        (cmd_code == `FCSD_CMD_RESET);
            end
            M_TOUT:  legal = (cmd_code == `FCSD_CMD_READ) || (cmd_code == `FCSD_CMD_RESET);
            M_ABORT: begin
                legal = (cmd_code == `FCSD_CMD_READ) || (cmd_code == `FCSD_CMD_ABORT_RST);
            end
            M_BUFLD: begin
                // an out-of-page load or early confirm would make the device abort
                if (cmd_code == `FCSD_CMD_BUF_LOAD) begin
                    legal = (left_ff != 6'h00) && (csect == sect_ff) &&
                            (!page_set_ff || (cpage == page_ff));
                end else if (cmd_code == `FCSD_CMD_BUF_CONF) begin
                    legal = (left_ff == 6'h00) && (csect == sect_ff);
                end
            end
            default: legal = 1'b0;
        endcase
    end

    // bus cycle table: step 0 and 1 are the unlock pair for multi-cycle commands
    always @* begin
        st_addr = u1;
        st_data = `FCSD_D_UNLOCK1;
        st_rd   = 1'b0;
        st_last = 1'b0;
        if (step_ff == 3'h1) begin
            st_addr = u2;
            st_data = `FCSD_D_UNLOCK2;
        end
        case (cmd_ff)
            `FCSD_CMD_READ: begin
                st_addr = addr_ff;
                st_rd   = 1'b1;
                st_last = 1'b1;
            end
            `FCSD_CMD_RESET: begin
                st_data = `FCSD_D_RESET;
                st_last = 1'b1;
            end
            `FCSD_CMD_SUSPEND: begin
                st_data = `FCSD_D_SUSPEND;
                st_last = 1'b1;
            end
            `FCSD_CMD_RESUME: begin
                st_data = `FCSD_D_RESUME;
                st_last = 1'b1;
            end
            `FCSD_CMD_QUERY: begin
                st_addr = uq;
                st_data = `FCSD_D_QUERY;
                st_last = 1'b1;
            end
            `FCSD_CMD_BUF_LOAD: begin
                st_addr = addr_ff;
                st_data = data_ff;
                st_last = 1'b1;
            end
            `FCSD_CMD_BUF_CONF: begin
                st_addr = addr_ff;
                st_data = `FCSD_D_BUF_CONF;
                st_last = 1'b1;
            end
            `FCSD_CMD_ASEL: begin
                if (step_ff == 3'h2) begin
                    st_data = `FCSD_D_ASEL;
                end else if (step_ff == 3'h3) begin
                    // offsets 00/01/0E/0F/03/(sector)02 come from the caller's address
                    st_addr = addr_ff;
                    st_rd   = 1'b1;
                    st_last = 1'b1;
                end
            end
            `FCSD_CMD_PROGRAM: begin
                if (step_ff == 3'h2) begin
                    st_data = `FCSD_D_PROGRAM;
                end else if (step_ff == 3'h3) begin
                    st_addr = addr_ff;
                    st_data = data_ff;
                    st_last = 1'b1;
                end
            end
            `FCSD_CMD_CHIP_ERS, `FCSD_CMD_SECT_ERS: begin
                case (step_ff)
                    3'h2: st_data = `FCSD_D_ERASE;
                    3'h3: st_data = `FCSD_D_UNLOCK1;
                    3'h4: begin
                        st_addr = u2;
                        st_data = `FCSD_D_UNLOCK2;
                    end
                    3'h5: begin
                        st_last = 1'b1;
                        if (cmd_ff == `FCSD_CMD_SECT_ERS) begin
                            st_addr = addr_ff;
                            st_data = `FCSD_D_SECT;
                        end else begin
                            st_data = `FCSD_D_CHIP;
                        end
                    end
                    default: st_rd = 1'b0;
                endcase
            end
            `FCSD_CMD_SEC_ENTER: begin
                st_data = (step_ff == 3'h2) ? `FCSD_D_SEC_EN : st_data;
                st_last = (step_ff == 3'h2);
            end
            `FCSD_CMD_SEC_EXIT: begin
                if (step_ff == 3'h2) begin
                    st_data = `FCSD_D_ASEL;
                end else if (step_ff == 3'h3) begin
                    st_data = `FCSD_D_SEC_EX;
                    st_last = 1'b1;
                end
            end
            `FCSD_CMD_BUF_START: begin
                if (step_ff == 3'h2) begin
                    st_addr = addr_ff;
                    st_data = `FCSD_D_BUF_LOAD;
                end else if (step_ff == 3'h3) begin
                    st_addr = addr_ff;
                    st_data = data_ff;
                    st_last = 1'b1;
                end
            end
            `FCSD_CMD_ABORT_RST: begin
                st_data = (step_ff == 3'h2) ? `FCSD_D_RESET : st_data;
                st_last = (step_ff == 3'h2);
            end
            default: st_last = 1'b1;
        endcase
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dq_meta_ff <= 16'h0000;
            dq_sync_ff <= 16'h0000;
        end else begin
            dq_meta_ff <= flash_dq_in;
            dq_sync_ff <= dq_meta_ff;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_ff           <= S_IDLE;
            cnt_ff          <= 8'h00;
            step_ff         <= 3'h0;
            cmd_ff          <= 4'h0;
            addr_ff         <= 22'h000000;
            data_ff         <= 16'h0000;
            byte_ff         <= 1'b0;
            sect_ff         <= 10'h000;
            page_ff         <= 18'h00000;
            page_set_ff     <= 1'b0;
            left_ff         <= 6'h00;
            mode_ff         <= M_READ;
            esusp_ff        <= 1'b0;
            cmd_ready_ff    <= 1'b0;
            cmd_err_ff      <= 1'b0;
            rd_data_ff      <= 16'h0000;
            rd_valid_ff     <= 1'b0;
            flash_ce_n_ff   <= 1'b1;
            flash_we_n_ff   <= 1'b1;
            flash_oe_n_ff   <= 1'b1;
            flash_byte_n_ff <= 1'b1;
            flash_addr_ff   <= 22'h000000;
            flash_dq_out_ff <= 16'h0000;
            flash_dq_oe_ff  <= 1'b0;
        end else begin
            cmd_err_ff  <= 1'b0;
            rd_valid_ff <= 1'b0;
            cnt_ff      <= cnt_ff + 8'h01;
            // algorithm status reported by the caller's polling
            if (st_ff == S_IDLE && !(cmd_valid && cmd_ready_ff)) begin
                if (timeout_flag_bit && (mode_ff == M_BUSY || mode_ff == M_SERS)) begin
                    mode_ff <= M_TOUT;
                end else if (op_abort && mode_ff == M_BUSY) begin
                    mode_ff <= M_ABORT;
                end else if (op_done && (mode_ff == M_BUSY || mode_ff == M_SERS)) begin
                    mode_ff  <= (esusp_ff && mode_ff == M_BUSY) ? M_ESUSP : M_READ;
                    esusp_ff <= esusp_ff && (mode_ff == M_BUSY);
                end
            end
            case (st_ff)
                S_IDLE: begin
                    cmd_ready_ff <= 1'b1;
                    if (cmd_valid && cmd_ready_ff) begin
                        if (legal) begin
                            cmd_ready_ff    <= 1'b0;
                            cmd_ff          <= cmd_code;
                            addr_ff         <= cmd_addr;
                            data_ff         <= cmd_data;
                            byte_ff         <= byte_mode;
                            flash_byte_n_ff <= ~byte_mode;
                            step_ff         <= (cmd_code < `FCSD_CMD_ASEL ||
                                                (cmd_code > `FCSD_CMD_SECT_ERS &&
                                                 cmd_code < `FCSD_CMD_SEC_ENTER) ||
                                                cmd_code == `FCSD_CMD_BUF_LOAD ||
                                                cmd_code == `FCSD_CMD_BUF_CONF) ?
                                               3'h0 : start_step;
                            st_ff           <= S_LOAD;
                        end else begin
                            cmd_err_ff <= 1'b1;
                        end
                    end
                end
                S_LOAD: begin
                    flash_addr_ff   <= st_addr;
                    flash_dq_out_ff <= byte_ff ? {8'h00, st_data[7:0]} : st_data;
                    flash_dq_oe_ff  <= ~st_rd;
                    flash_ce_n_ff   <= 1'b0;
                    cnt_ff          <= 8'h01;
                    st_ff           <= S_SETUP;
                end
                S_SETUP: begin
                    if (cnt_su) begin
                        // strobe falls after chip enable so the address is taken here
                        flash_we_n_ff <= st_rd;
                        flash_oe_n_ff <= ~st_rd;
                        cnt_ff        <= 8'h01;
                        st_ff         <= S_PULSE;
                    end
                end
                S_PULSE: begin
                    if (cnt_pw) begin
                        flash_we_n_ff <= 1'b1;
                        flash_oe_n_ff <= 1'b1;
                        if (st_rd) begin
                            rd_data_ff  <= byte_ff ? {8'h00, dq_sync_ff[7:0]} : dq_sync_ff;
                            rd_valid_ff <= 1'b1;
                        end
                        cnt_ff <= 8'h01;
                        st_ff  <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    // data held past the strobe rise; chip enable rises after it
                    flash_ce_n_ff <= 1'b1;
                    if (cnt_wph) begin
                        flash_dq_oe_ff <= 1'b0;
                        if (!st_last) begin
                            step_ff <= step_ff + 3'h1;
                            st_ff   <= S_LOAD;
                        end else begin
                            st_ff <= S_IDLE;
                            case (cmd_ff)
                                `FCSD_CMD_RESET, `FCSD_CMD_ABORT_RST,
                                `FCSD_CMD_SEC_ENTER, `FCSD_CMD_SEC_EXIT: begin
                                    mode_ff <= esusp_ff ? M_ESUSP : M_READ;
                                end
                                `FCSD_CMD_ASEL:     mode_ff <= M_ASEL;
                                `FCSD_CMD_QUERY:    mode_ff <= M_QUERY;
                                `FCSD_CMD_PROGRAM,
                                `FCSD_CMD_CHIP_ERS,
                                `FCSD_CMD_BUF_CONF: mode_ff <= M_BUSY;
                                `FCSD_CMD_SECT_ERS: mode_ff <= M_SERS;
                                `FCSD_CMD_SUSPEND: begin
                                    mode_ff  <= M_ESUSP;
                                    esusp_ff <= 1'b1;
                                end
                                `FCSD_CMD_RESUME: begin
                                    mode_ff  <= M_SERS;
                                    esusp_ff <= 1'b0;
                                end
                                `FCSD_CMD_BUF_START: begin
                                    mode_ff     <= M_BUFLD;
                                    sect_ff     <= addr_ff[`FCSD_SECT_HI:`FCSD_SECT_LO];
                                    page_set_ff <= 1'b0;
                                    left_ff     <= data_ff[5:0] + 6'h01;
                                end
                                `FCSD_CMD_BUF_LOAD: begin
                                    left_ff     <= left_ff - 6'h01;
                                    page_set_ff <= 1'b1;
                                    if (!page_set_ff) begin
                                        page_ff <= byte_ff ? {1'b0, addr_ff[21:5]} : addr_ff[21:4];
                                    end
                                end
                                default: mode_ff <= mode_ff;
                            endcase
                        end
                    end
                end
                default: st_ff <= S_IDLE;
            endcase
        end
    end

endmodule

// ### inc/fcsd_regs.vh
// Summary of operation
// - command cycles are writes, except data reads
// - program is AA, 55, A0, then address/data
// - plain reads need no command cycles
// - F0 reset leaves select mode or timeout
// - select entry is two unlocks then 90
// - buffer program: 25, count-1, pairs, 29
// - buffer sequence at most 21/37 cycles
// - buffer loads stay in first page
// - aborted buffer needs three-cycle abort reset
// - chip erase ends 10, sector 30
`ifndef FCSD_REGS_VH
`define FCSD_REGS_VH

`define FCSD_CMD_READ      4'h0
`define FCSD_CMD_RESET     4'h1
`define FCSD_CMD_ASEL      4'h2
`define FCSD_CMD_PROGRAM   4'h3
`define FCSD_CMD_CHIP_ERS  4'h4
`define FCSD_CMD_SECT_ERS  4'h5
`define FCSD_CMD_SUSPEND   4'h6
`define FCSD_CMD_RESUME    4'h7
`define FCSD_CMD_QUERY     4'h8
`define FCSD_CMD_SEC_ENTER 4'h9
`define FCSD_CMD_SEC_EXIT  4'hA
`define FCSD_CMD_BUF_START 4'hB
`define FCSD_CMD_BUF_LOAD  4'hC
`define FCSD_CMD_BUF_CONF  4'hD
`define FCSD_CMD_ABORT_RST 4'hE

`define FCSD_D_UNLOCK1  16'h00AA
`define FCSD_D_UNLOCK2  16'h0055
`define FCSD_D_RESET    16'h00F0
`define FCSD_D_ASEL     16'h0090
`define FCSD_D_PROGRAM  16'h00A0
`define FCSD_D_ERASE    16'h0080
`define FCSD_D_CHIP     16'h0010
`define FCSD_D_SECT     16'h0030
`define FCSD_D_SUSPEND  16'h00B0
`define FCSD_D_RESUME   16'h0030
`define FCSD_D_QUERY    16'h0098
`define FCSD_D_SEC_EN   16'h0088
`define FCSD_D_SEC_EX   16'h0000
`define FCSD_D_BUF_LOAD 16'h0025
`define FCSD_D_BUF_CONF 16'h0029

`define FCSD_A_U1_WORD  22'h000555
`define FCSD_A_U2_WORD  22'h0002AA
`define FCSD_A_U1_BYTE  22'h000AAA
`define FCSD_A_U2_BYTE  22'h000555
`define FCSD_A_Q_WORD   22'h000055
`define FCSD_A_Q_BYTE   22'h0000AA

`define FCSD_SECT_HI    21
`define FCSD_SECT_LO    12
`define FCSD_BUF_MAX_W  16'h000F
`define FCSD_BUF_MAX_B  16'h001F

`define FCSD_CLK_NS     4
`define FCSD_T_SU_NS    10
`define FCSD_T_WP_NS    35
`define FCSD_T_WPH_NS   30
`define FCSD_T_ACC_NS   90
`define FCSD_SYNC_CYC   2
`define FCSD_C_SU  ((`FCSD_T_SU_NS + `FCSD_CLK_NS - 1) / `FCSD_CLK_NS)
`define FCSD_C_WP  ((`FCSD_T_WP_NS + `FCSD_CLK_NS - 1) / `FCSD_CLK_NS)
`define FCSD_C_WPH ((`FCSD_T_WPH_NS + `FCSD_CLK_NS - 1) / `FCSD_CLK_NS)
`define FCSD_C_RD  ((`FCSD_T_ACC_NS + `FCSD_CLK_NS - 1) / `FCSD_CLK_NS + `FCSD_SYNC_CYC)

`endif

// ### sim/fcsd_flash_model.sv
`timescale 1ns/1ps
module fcsd_flash_model #(
    parameter [15:0] MFR  = 16'h005E, // arbitrary maker code
    parameter [15:0] STAT = 16'h00C8
) (
    input  wire        ce_n,
    input  wire        we_n,
    input  wire        oe_n,
    input  wire        byte_n,
    input  wire [21:0] addr,
    input  wire [15:0] dq_h,
    output wire [15:0] dq_o
);
    reg  [15:0] mem [0:255];
    reg  [21:0] la;
    reg  [9:0]  es;
    reg  [2:0]  st, md;
    reg  [15:0] lastv;
    wire [7:0]  d  = dq_h[7:0];
    wire        u1 = la[10:0] == (byte_n ? 11'h555 : 11'hAAA);
    wire        u2 = la[10:0] == (byte_n ? 11'h2AA : 11'h555);
    wire        in_es = (md == 3'd3 || md == 3'd4) && addr[21:12] == es;
    wire [15:0] rv = in_es ? STAT : (md == 3'd1) ?
        (addr[1] ? {15'h0000, addr[12]} : MFR) : mem[addr[7:0]];
    // released bus shows the inverse so a stale sample cannot match
    assign dq_o = (!ce_n && !oe_n) ? rv : ~lastv;
    initial {st, md, lastv} = 0;
    always @(posedge oe_n) lastv <= rv;
    always @(negedge we_n or negedge ce_n)
        if (!we_n && !ce_n && oe_n) la <= addr;
    always @(posedge we_n or posedge ce_n)
        if (we_n != ce_n) case (st)
            3'd0: if (md == 3'd2) {mem[la[7:0]], md} <= {dq_h, 3'd0};
                else if (d == 8'hAA && u1) st <= 3'd1;
                else if (d == 8'hF0 && md != 3'd3) md <= 3'd0;
                else if (d == 8'hB0 && md == 3'd3) md <= 3'd4;
                else if (d == 8'h30 && md == 3'd4) md <= 3'd3;
            3'd1, 3'd4: st <= (d == 8'h55 && u2) ? st + 3'd1 : 3'd0;
            3'd2: begin
                st <= (d == 8'h80) ? 3'd3 : 3'd0;
                md <= (d == 8'h90) ? 3'd1 : (d == 8'hA0) ? 3'd2 : md;
            end
            3'd3: st <= (d == 8'hAA && u1) ? 3'd4 : 3'd0;
            default: begin
                st <= 3'd0;
                if (d == 8'h30) {md, es} <= {3'd3, la[21:12]};
            end
        endcase
endmodule

// ### sim/fcsd_host_props.sv
`timescale 1ns/1ps
module fcsd_host_props (
    input wire        clk,
    input wire        nrst,
    input wire        cmd_valid,
    input wire        cmd_ready_ff,
    input wire        cmd_err_ff,
    input wire        rd_valid_ff,
    input wire        flash_ce_n_ff,
    input wire        flash_we_n_ff,
    input wire        flash_oe_n_ff,
    input wire        flash_dq_oe_ff,
    input wire [15:0] flash_dq_out_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_wpulse;
        !flash_we_n_ff [*8] ##1 !flash_we_n_ff ##1 flash_we_n_ff;
    endsequence
    a_take_answered: assert property (cmd_valid && cmd_ready_ff |=>
        cmd_ready_ff == cmd_err_ff) else $error("take answered wrongly");
    a_refuse_idle: assert property (cmd_err_ff |->
        cmd_ready_ff && flash_ce_n_ff) else $error("refusal touched the bus");
    a_write_strobes: assert property (!flash_we_n_ff |->
        !flash_ce_n_ff && flash_oe_n_ff && flash_dq_oe_ff) else $error("write strobes");
    a_we_width: assert property ($fell(flash_we_n_ff) |-> s_wpulse)
        else $error("write pulse width");
    a_data_hold: assert property ($rose(flash_we_n_ff) |->
        flash_dq_oe_ff && $stable(flash_dq_out_ff)) else $error("data moved at latch");
    a_read_bus: assert property (!flash_oe_n_ff |->
        flash_we_n_ff && !flash_dq_oe_ff && !flash_ce_n_ff) else $error("read contention");
    a_read_valid: assert property (rd_valid_ff |-> $rose(flash_oe_n_ff))
        else $error("read data not at pulse end");
    a_idle_bus: assert property (cmd_ready_ff |->
        flash_ce_n_ff && flash_oe_n_ff && !flash_dq_oe_ff) else $error("bus busy while idle");
endmodule

bind fcsd_host fcsd_host_props u_props (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid),
    .cmd_ready_ff(cmd_ready_ff), .cmd_err_ff(cmd_err_ff), .rd_valid_ff(rd_valid_ff),
    .flash_ce_n_ff(flash_ce_n_ff), .flash_we_n_ff(flash_we_n_ff),
    .flash_oe_n_ff(flash_oe_n_ff), .flash_dq_oe_ff(flash_dq_oe_ff),
    .flash_dq_out_ff(flash_dq_out_ff));

// ### sim/testbench.sv
`timescale 1ns/1ps
`include "fcsd_regs.vh"
module testbench;
    localparam [15:0] MFR  = 16'h005E; // arbitrary maker code
    localparam [15:0] STAT = 16'h00C8;
    reg         clk, nrst, cmd_valid, byte_mode, op_done, op_abort, tmo;
    reg  [3:0]  cmd_code;
    reg  [21:0] cmd_addr;
    reg  [15:0] cmd_data;
    integer     n_mismatch, samples_checked, cyc, b;
    wire        rdy, err, rdv, es, ce_n, we_n, oe_n, byte_n, dq_oe;
    wire [3:0]  mode;
    wire [21:0] fa;
    wire [15:0] rd, dq_out, m_dq;
    wire [15:0] dq_in = dq_oe ? dq_out : m_dq;
    fcsd_host dut (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .byte_mode(byte_mode), .op_done(op_done),
        .op_abort(op_abort), .timeout_flag_bit(tmo), .cmd_ready_ff(rdy), .cmd_err_ff(err),
        .rd_data_ff(rd), .rd_valid_ff(rdv), .mode_ff(mode), .esusp_ff(es), .flash_ce_n_ff(ce_n),
        .flash_we_n_ff(we_n), .flash_oe_n_ff(oe_n), .flash_byte_n_ff(byte_n),
        .flash_addr_ff(fa), .flash_dq_out_ff(dq_out), .flash_dq_oe_ff(dq_oe),
        .flash_dq_in(dq_in));
    fcsd_flash_model #(.MFR(MFR), .STAT(STAT)) u_flash (.ce_n(ce_n), .we_n(we_n),
        .oe_n(oe_n), .byte_n(byte_n), .addr(fa), .dq_h(dq_out), .dq_o(m_dq));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task chk(input string nm, input [15:0] seen, input [15:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("BAD %s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // one-cycle status pulse while idle: 0 done, 1 abort, 2 timeout
    task pulse(input [1:0] k);
        {tmo, op_abort, op_done} = 3'h1 << k;
        @(negedge clk);
        {tmo, op_abort, op_done} = 3'h0;
        @(negedge clk);
    endtask
    // one request; waits for idle before and after, refusal flag checked
    task cmd(input [3:0] c, input [21:0] a, input [15:0] d, input xe);
        integer i;
        begin
            @(negedge clk);
            for (i = 0; i < 600 && rdy !== 1'b1; i = i + 1) @(negedge clk);
            {cmd_code, cmd_addr, cmd_data, cmd_valid} = {c, a, d, 1'b1};
            @(negedge clk);
            cmd_valid = 1'b0;
            chk("refused", {15'h0000, err}, {15'h0000, xe});
            for (i = 0; i < 600 && rdy !== 1'b1; i = i + 1) @(negedge clk);
        end
    endtask
    task t_program;
        for (b = 0; b < 2; b = b + 1) begin
            byte_mode = b[0];
            cmd(`FCSD_CMD_PROGRAM, {21'h000008, b[0]}, {15'h002D, b[0]}, 1'b0);
            chk("byte pin", {15'h0000, byte_n}, {15'h0000, ~b[0]});
            cmd(`FCSD_CMD_READ, {21'h000008, b[0]}, 16'h0000, 1'b0);
            chk("prog data", rd, {15'h002D, b[0]});
            pulse({b[0], 1'b0});
        end
        byte_mode = 1'b0;
        chk("timeout", {12'h000, mode}, 16'h0008);
        cmd(`FCSD_CMD_RESET, 22'h000000, 16'h0000, 1'b0);
        $display("t_program done");
    endtask
    task t_buf;
        cmd(`FCSD_CMD_BUF_START, 22'h006000, 16'h0001, 1'b0);
        chk("loading", {12'h000, mode}, 16'h0007);
        cmd(`FCSD_CMD_BUF_LOAD, 22'h006000, 16'h1111, 1'b0);
        cmd(`FCSD_CMD_BUF_LOAD, 22'h006010, 16'h1111, 1'b1);
        cmd(`FCSD_CMD_BUF_CONF, 22'h006000, 16'h0000, 1'b1);
        cmd(`FCSD_CMD_BUF_LOAD, 22'h006003, 16'h1111, 1'b0);
        cmd(`FCSD_CMD_BUF_CONF, 22'h006000, 16'h0000, 1'b0);
        pulse(1);
        chk("aborted", {12'h000, mode}, 16'h0006);
        cmd(`FCSD_CMD_ABORT_RST, 22'h000000, 16'h0000, 1'b0);
        $display("t_buf done");
    endtask
    task t_asel;
        cmd(`FCSD_CMD_SUSPEND, 22'h000000, 16'h0000, 1'b1);
        cmd(`FCSD_CMD_RESUME, 22'h000000, 16'h0000, 1'b1);
        cmd(`FCSD_CMD_BUF_START, 22'h003000, 16'h0010, 1'b1);
        cmd(`FCSD_CMD_ASEL, 22'h000000, 16'h0000, 1'b0);
        chk("maker", rd, MFR);
        cmd(`FCSD_CMD_PROGRAM, 22'h000010, 16'h1234, 1'b1);
        cmd(`FCSD_CMD_ASEL, 22'h003002, 16'h0000, 1'b0);
        chk("protect", rd, 16'h0001);
        cmd(`FCSD_CMD_QUERY, 22'h000000, 16'h0000, 1'b0);
        cmd(`FCSD_CMD_RESET, 22'h000000, 16'h0000, 1'b0);
        chk("mode", {12'h000, mode}, 16'h0000);
        cmd(`FCSD_CMD_READ, 22'h000010, 16'h0000, 1'b0);
        chk("array", rd, 16'h005A);
        $display("t_asel done");
    endtask
    task t_erase;
        cmd(`FCSD_CMD_SECT_ERS, 22'h005000, 16'h0000, 1'b0);
        chk("mode", {12'h000, mode}, 16'h0004);
        cmd(`FCSD_CMD_RESET, 22'h000000, 16'h0000, 1'b1);
        cmd(`FCSD_CMD_QUERY, 22'h000000, 16'h0000, 1'b1);
        cmd(`FCSD_CMD_SUSPEND, 22'h000000, 16'h0000, 1'b0);
        chk("suspended", {11'h000, es, mode}, 16'h0015);
        cmd(`FCSD_CMD_READ, 22'h005010, 16'h0000, 1'b0);
        chk("status", rd, STAT);
        cmd(`FCSD_CMD_READ, 22'h000010, 16'h0000, 1'b0);
        chk("outside", rd, 16'h005A);
        cmd(`FCSD_CMD_RESUME, 22'h000000, 16'h0000, 1'b0);
        chk("resumed", {11'h000, es, mode}, 16'h0004);
        pulse(0);
        chk("done", {12'h000, mode}, 16'h0000);
        $display("t_erase done");
    endtask
    task results;
        begin
            $display("checked %0d mismatched %0d", samples_checked, n_mismatch);
            if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // whole run needs about 1000 cycles
    always @(negedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            results;
        end
    end
    initial begin
        {nrst, cmd_valid, byte_mode, op_done, op_abort, tmo, cmd_code, cmd_addr, cmd_data} = 0;
        {n_mismatch, samples_checked, cyc} = 0;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        t_program;
        t_buf;
        t_asel;
        t_erase;
        results;
    end
endmodule
